//--- include/csrs_pkg.sv
// Package: register map, field positions, codes and states of the soft reset sequencer
package csrs_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_INT_STAT = 5'h08;
  localparam logic [4:0] OFF_INT_MASK = 5'h0C;

  // Control register fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_BRK_CFG = 1;
  localparam int CTRL_VERB_LO = 2;
  localparam int CTRL_START_CUR = 4;
  localparam int CTRL_CUR_ON = 5;
  localparam int CTRL_ALM_GATE = 6;
  localparam logic [1:0] VERB_BANNER = 2'h1;

  // Status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_STEP_LO = 1;
  localparam int ST_CUR = 5;
  localparam int ST_BRK_CLOSED = 6;
  localparam int ST_FOLLOW = 7;
  localparam int ST_ALM_LO = 8;

  // Interrupt events, one sticky bit each
  localparam int NEV = 4;
  localparam int EV_START = 0;
  localparam int EV_DONE = 1;
  localparam int EV_AUTO = 2;
  localparam int EV_ALARM = 3;
  localparam logic [NEV-1:0] MASK_RST = 4'h0;

  // External services, each a request and acknowledge pair
  localparam int NSVC = 4;
  localparam int SVC_TX = 0;
  localparam int SVC_NVM = 1;
  localparam int SVC_ALM = 2;
  localparam int SVC_INP = 3;

  // Text messages sent over the command link
  localparam logic [1:0] MSG_NONE = 2'h0;
  localparam logic [1:0] MSG_RESETTING = 2'h1;
  localparam logic [1:0] MSG_BANNER = 2'h2;
  localparam logic [1:0] MSG_PROMPT = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_CUR_OFF = 4'h1,
    ST_NOTICE = 4'h2,
    ST_OUT_OPEN = 4'h3,
    ST_RELOAD = 4'h4,
    ST_ALARM = 4'h5,
    ST_CUR_ON = 4'h6,
    ST_OUT_SET = 4'h7,
    ST_BANNER = 4'h8,
    ST_PROMPT = 4'h9,
    ST_BRAKE = 4'hA,
    ST_INPUTS = 4'hB,
    ST_AUTOSTART = 4'hC
  } csrs_state_e;

  typedef struct packed {
    logic alarm_gate;
    logic current_on_request;
    logic start_current_setting;
    logic [1:0] banner_verbosity_setting;
    logic brake_configured;
  } csrs_cfg_s;

  localparam csrs_cfg_s CFG_RST = '0;

endpackage

//--- src/csrs_hs.sv
// Request and acknowledge holder for one external service of the sequencer
module csrs_hs
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Sequencer side
  input wire logic start,
  output logic done,
  // Service side
  output logic req,
  input wire logic ack
);

  logic next_req;
  logic next_done;

  // Request stays up until the service acknowledges; an ack without a request is ignored
  always_comb
  begin
    next_req = start | (req & ~ack);
    next_done = req & ack;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      req <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      req <= next_req;
      done <= next_done;
    end
  end

endmodule

//--- src/csrs_irq.sv
// Sticky interrupt status with read clear, mask and one level interrupt
module csrs_irq #(
  parameter int W = 4
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Events and software access
  input wire logic [W-1:0] set,
  input wire logic rd_clear,
  input wire logic [W-1:0] mask,
  // Results
  output logic [W-1:0] status,
  output logic irq
);

  logic [W-1:0] next_status;
  logic next_irq;

  // An event in the clearing cycle survives the read that clears the rest
  always_comb
  begin
    next_status = set | (status & ~{W{rd_clear}});
    next_irq = |(next_status & mask);
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      status <= '0;
      irq <= 1'b0;
    end
    else
    begin
      status <= next_status;
      irq <= next_irq;
    end
  end

endmodule

//--- src/csrs_seq.sv
// Soft reset sequencer of the motion controller with its Avalon-MM register slave
module csrs_seq
  import csrs_pkg::*;
#(
  parameter int ALM_W = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [csrs_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Reset command decoded from the command link
  input wire logic reset_cmd,
  // Service handshakes and message selection
  output logic [csrs_pkg::NSVC-1:0] svc_req,
  input wire logic [csrs_pkg::NSVC-1:0] svc_ack,
  output logic [1:0] tx_msg,
  // Conditions of the rest of the controller
  input wire logic [ALM_W-1:0] alarm_code_in,
  input wire logic current_on_input,
  input wire logic seq_running,
  input wire logic startup_seq_exists,
  // Drives
  output logic motor_current_en,
  output logic brake_release_output,
  output logic outputs_follow,
  output logic restart_hold,
  output logic startup_start,
  output logic irq
);

  import csrs_pkg::*;

  csrs_state_e state;
  csrs_state_e next_state;
  csrs_cfg_s cfg;
  csrs_cfg_s next_cfg;
  logic [NEV-1:0] int_mask;
  logic [NEV-1:0] next_int_mask;
  logic [NEV-1:0] int_stat;
  logic [NEV-1:0] ev;
  logic [NEV-1:0] next_ev;
  logic [NSVC-1:0] svc_start;
  logic [NSVC-1:0] next_svc_start;
  logic [NSVC-1:0] svc_done;
  logic [ALM_W-1:0] alarm;
  logic [ALM_W-1:0] next_alarm;
  logic [1:0] next_tx_msg;
  logic next_cur;
  logic next_brake;
  logic next_follow;
  logic next_hold;
  logic next_startup;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic acc;
  logic go;
  logic rd_clear;
  logic permit;

  // Bus: every access is answered one cycle after it is seen
  always_comb
  begin
    acc = (avs_read | avs_write) & avs_waitrequest;
    next_waitrequest = ~acc;
    next_cfg = cfg;
    next_int_mask = int_mask;
    next_readdata = avs_readdata;
    go = reset_cmd;
    rd_clear = 1'b0;
    if (acc && avs_write && avs_byteenable[0])
    begin
      if (avs_address == OFF_CTRL)
      begin
        next_cfg.brake_configured = avs_writedata[CTRL_BRK_CFG];
        next_cfg.banner_verbosity_setting = avs_writedata[CTRL_VERB_LO +: 2];
        next_cfg.start_current_setting = avs_writedata[CTRL_START_CUR];
        next_cfg.current_on_request = avs_writedata[CTRL_CUR_ON];
        next_cfg.alarm_gate = avs_writedata[CTRL_ALM_GATE];
        go = reset_cmd | avs_writedata[CTRL_GO];
      end
      else if (avs_address == OFF_INT_MASK)
      begin
        next_int_mask = avs_writedata[NEV-1:0];
      end
    end
    if (acc && avs_read)
    begin
      next_readdata = 32'h0;
      unique case (avs_address)
        OFF_CTRL:
        begin
          next_readdata[CTRL_BRK_CFG] = cfg.brake_configured;
          next_readdata[CTRL_VERB_LO +: 2] = cfg.banner_verbosity_setting;
          next_readdata[CTRL_START_CUR] = cfg.start_current_setting;
          next_readdata[CTRL_CUR_ON] = cfg.current_on_request;
          next_readdata[CTRL_ALM_GATE] = cfg.alarm_gate;
        end
        OFF_STATUS:
        begin
          next_readdata[ST_BUSY] = (state != ST_IDLE);
          next_readdata[ST_STEP_LO +: 4] = state;
          next_readdata[ST_CUR] = motor_current_en;
          next_readdata[ST_BRK_CLOSED] = brake_release_output;
          next_readdata[ST_FOLLOW] = outputs_follow;
          next_readdata[ST_ALM_LO +: ALM_W] = alarm;
        end
        OFF_INT_STAT:
        begin
          next_readdata[NEV-1:0] = int_stat;
          rd_clear = 1'b1;
        end
        OFF_INT_MASK:
        begin
          next_readdata[NEV-1:0] = int_mask;
        end
        default:
        begin
          next_readdata = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cfg <= CFG_RST;
      int_mask <= MASK_RST;
      avs_readdata <= 32'h0;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      cfg <= next_cfg;
      int_mask <= next_int_mask;
      avs_readdata <= next_readdata;
      avs_waitrequest <= next_waitrequest;
    end
  end

  // Current may return only with no gating alarm and at least one request to run
  assign permit = (~cfg.alarm_gate | (alarm == '0)) &
                  (cfg.start_current_setting | cfg.current_on_request | current_on_input);

  // Sequencer: each step waits for its service to finish before the next starts
  always_comb
  begin
    next_state = state;
    next_cur = motor_current_en;
    next_brake = brake_release_output;
    next_follow = outputs_follow;
    next_hold = restart_hold;
    next_alarm = alarm;
    next_tx_msg = tx_msg;
    next_svc_start = '0;
    next_ev = '0;
    next_startup = 1'b0;
    unique case (state)
      ST_IDLE:
      begin
        // A request during a running reset is ignored
        if (go)
        begin
          next_state = ST_CUR_OFF;
          next_hold = 1'b1;
          next_ev[EV_START] = 1'b1;
        end
      end
      ST_CUR_OFF:
      begin
        next_cur = 1'b0;
        if (cfg.brake_configured)
        begin
          next_brake = 1'b0;
        end
        next_tx_msg = MSG_RESETTING;
        next_svc_start[SVC_TX] = 1'b1;
        next_state = ST_NOTICE;
      end
      ST_NOTICE:
      begin
        if (svc_done[SVC_TX])
        begin
          next_state = ST_OUT_OPEN;
        end
      end
      ST_OUT_OPEN:
      begin
        next_follow = 1'b0;
        next_svc_start[SVC_NVM] = 1'b1;
        next_state = ST_RELOAD;
      end
      ST_RELOAD:
      begin
        if (svc_done[SVC_NVM])
        begin
          next_svc_start[SVC_ALM] = 1'b1;
          next_state = ST_ALARM;
        end
      end
      ST_ALARM:
      begin
        if (svc_done[SVC_ALM])
        begin
          next_alarm = alarm_code_in;
          next_ev[EV_ALARM] = (alarm_code_in != '0);
          next_state = ST_CUR_ON;
        end
      end
      ST_CUR_ON:
      begin
        next_cur = permit;
        next_state = ST_OUT_SET;
      end
      ST_OUT_SET:
      begin
        // Brake release output keeps its value here, opened at ST_CUR_OFF only if the brake is configured
        next_follow = 1'b1;
        next_svc_start[SVC_TX] = 1'b1;
        if (cfg.banner_verbosity_setting == VERB_BANNER)
        begin
          next_tx_msg = MSG_BANNER;
          next_state = ST_BANNER;
        end
        else
        begin
          next_tx_msg = MSG_PROMPT;
          next_state = ST_PROMPT;
        end
      end
      ST_BANNER:
      begin
        if (svc_done[SVC_TX])
        begin
          next_tx_msg = MSG_PROMPT;
          next_svc_start[SVC_TX] = 1'b1;
          next_state = ST_PROMPT;
        end
      end
      ST_PROMPT:
      begin
        if (svc_done[SVC_TX])
        begin
          next_tx_msg = MSG_NONE;
          next_state = ST_BRAKE;
        end
      end
      ST_BRAKE:
      begin
        if (motor_current_en && cfg.brake_configured)
        begin
          next_brake = 1'b1;
        end
        // The rest of the controller runs again so input actions can take effect
        next_hold = 1'b0;
        next_svc_start[SVC_INP] = 1'b1;
        next_state = ST_INPUTS;
      end
      ST_INPUTS:
      begin
        if (svc_done[SVC_INP])
        begin
          next_state = ST_AUTOSTART;
        end
      end
      ST_AUTOSTART:
      begin
        // Alarm is sampled live since input actions may have raised one
        if ((alarm_code_in == '0) && !seq_running && startup_seq_exists)
        begin
          next_startup = 1'b1;
          next_ev[EV_AUTO] = 1'b1;
        end
        next_alarm = alarm_code_in;
        next_ev[EV_DONE] = 1'b1;
        next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state <= ST_IDLE;
      motor_current_en <= 1'b0;
      brake_release_output <= 1'b0;
      outputs_follow <= 1'b0;
      restart_hold <= 1'b0;
      alarm <= '0;
      tx_msg <= MSG_NONE;
      svc_start <= '0;
      ev <= '0;
      startup_start <= 1'b0;
    end
    else
    begin
      state <= next_state;
      motor_current_en <= next_cur;
      brake_release_output <= next_brake;
      outputs_follow <= next_follow;
      restart_hold <= next_hold;
      alarm <= next_alarm;
      tx_msg <= next_tx_msg;
      svc_start <= next_svc_start;
      ev <= next_ev;
      startup_start <= next_startup;
    end
  end

  // One holder per service: message send, storage reload, alarm check, input sampling
  for (genvar i = 0; i < NSVC; i++)
  begin : g_svc
    csrs_hs u_hs (
      .clk(clk),
      .rstn(rstn),
      .start(svc_start[i]),
      .done(svc_done[i]),
      .req(svc_req[i]),
      .ack(svc_ack[i])
    );
  end

  csrs_irq #(
    .W(NEV)
  ) u_irq (
    .clk(clk),
    .rstn(rstn),
    .set(ev),
    .rd_clear(rd_clear),
    .mask(int_mask),
    .status(int_stat),
    .irq(irq)
  );

endmodule

//--- tb/csrs_props.sv
// Checker of the soft reset sequencer port behaviour
module csrs_props
  import csrs_pkg::*;
#(
  parameter int ALM_W = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Services
  input wire logic [csrs_pkg::NSVC-1:0] svc_req,
  input wire logic [csrs_pkg::NSVC-1:0] svc_ack,
  input wire logic [1:0] tx_msg,
  // Conditions and drives
  input wire logic [ALM_W-1:0] alarm_code_in,
  input wire logic seq_running,
  input wire logic startup_seq_exists,
  input wire logic motor_current_en,
  input wire logic brake_release_output,
  input wire logic outputs_follow,
  input wire logic restart_hold,
  input wire logic startup_start
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");
  a_current_off_first: assert property ($rose(restart_hold) |=> !motor_current_en)
    else $error("current not removed first");
  a_notice_next: assert property ($rose(restart_hold) |-> ##2 svc_req[SVC_TX] && tx_msg == MSG_RESETTING)
    else $error("resetting notice missing");
  a_one_service: assert property ($onehot0(svc_req))
    else $error("services overlap");
  a_req_stands: assert property (svc_req != '0 && svc_ack == '0 |=> $stable(svc_req))
    else $error("service request dropped early");
  a_open_on_reload: assert property (svc_req[SVC_NVM] |-> !outputs_follow && !motor_current_en && restart_hold)
    else $error("outputs not open at reload");
  a_off_at_alarm: assert property (svc_req[SVC_ALM] |-> !motor_current_en && !outputs_follow)
    else $error("current on before alarm check");
  a_text_valid: assert property (svc_req[SVC_TX] |-> tx_msg != MSG_NONE)
    else $error("text request without message");
  a_brake_cond: assert property ($rose(brake_release_output) |-> motor_current_en && outputs_follow)
    else $error("brake closed without current");
  a_inputs_late: assert property (svc_req[SVC_INP] |-> !restart_hold && outputs_follow)
    else $error("inputs sampled while held");
  a_start_cond: assert property (startup_start |-> $past(alarm_code_in) == 0 && $past(startup_seq_exists)
    && !$past(seq_running) ##1 !startup_start)
    else $error("startup launch not allowed");
endmodule
bind csrs_seq csrs_props #(.ALM_W(ALM_W)) i_csrs_props (.clk, .rstn, .avs_read, .avs_write, .avs_waitrequest,
  .svc_req, .svc_ack, .tx_msg, .alarm_code_in, .seq_running, .startup_seq_exists, .motor_current_en,
  .brake_release_output, .outputs_follow, .restart_hold, .startup_start);

//--- tb/csrs_svc_model.sv
// Model of the controller services that answer the sequencer
module csrs_svc_model
  import csrs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Sequencer side
  input wire logic [csrs_pkg::NSVC-1:0] svc_req,
  input wire logic [1:0] tx_msg,
  output logic [csrs_pkg::NSVC-1:0] svc_ack,
  // Answer delay and record of finished services
  input wire logic [3:0] delay,
  output logic [31:0] hist,
  output logic [7:0] n_done
);
  logic [3:0] wait_cnt;
  always_ff @(posedge clk)
  begin
    svc_ack <= '0;
    if (!rstn)
    begin
      wait_cnt <= '0;
      hist <= '0;
      n_done <= '0;
    end
    else if (svc_req != '0 && svc_ack == '0)
    begin
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt >= delay)
      begin
        // Single pulse: text sent, store reloaded, alarms checked or inputs acted on
        svc_ack <= svc_req;
        wait_cnt <= '0;
        hist <= {hist[27:0], svc_req[3] | svc_req[2], svc_req[3] | svc_req[1], svc_req[0] ? tx_msg : 2'h0};
        n_done <= n_done + 8'h1;
      end
    end
  end
endmodule

//--- tb/tb.sv
// Self-checking bench of the soft reset sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import csrs_pkg::*;
  logic clk, rstn, avs_read, avs_write, avs_waitrequest, reset_cmd, current_on_input, seq_running;
  logic startup_seq_exists, motor_current_en, brake_release_output, outputs_follow, restart_hold;
  logic startup_start, irq, pm, st, brk;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rnd, q, hist;
  logic [3:0] avs_byteenable, svc_req, svc_ack, delay;
  logic [1:0] tx_msg;
  logic [7:0] alarm_code_in, n_done, n0;
  logic [5:0] cfg;
  int fail_count = 0;
  int checks = 0;
  int starts = 0;
  int s0, k;
  csrs_seq i_csrs_seq (.clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .reset_cmd, .svc_req, .svc_ack, .tx_msg, .alarm_code_in, .current_on_input,
    .seq_running, .startup_seq_exists, .motor_current_en, .brake_release_output, .outputs_follow,
    .restart_hold, .startup_start, .irq);
  csrs_svc_model i_csrs_svc_model (.clk, .rstn, .svc_req, .tx_msg, .svc_ack, .delay, .hist, .n_done);
  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
    if (startup_start === 1'b1)
      starts <= starts + 1;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Current may return only if the alarm gate allows it and some request asks for it
  function automatic logic permit(input logic [5:0] c, input logic [7:0] a, input logic ci);
    return (!c[5] || a == 8'h00) && (c[3] || c[4] || ci);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One Avalon access held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    if (n >= 20)
      chk(0, 1, "bus timeout");
    avs_read <= 0;
    avs_write <= 0;
    @(posedge clk);
  endtask
  initial
  begin
    #(40 * 20000);
    fail_count++;
    finish_test();
  end
  initial
  begin
    {rstn, avs_address, avs_read, avs_write, avs_writedata, avs_byteenable, reset_cmd} = '0;
    {alarm_code_in, current_on_input, seq_running, startup_seq_exists, delay} = '0;
    rnd = 32'hDF87;
    brk = 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    bus(1, OFF_INT_MASK, 32'hF, 4'h0);
    bus(0, OFF_INT_MASK, 0, 4'hF);
    chk(q, 0, "write without byte enable");
    bus(0, 5'h10, 0, 4'hF);
    chk(q, 0, "unmapped read");
    for (int i = 0; i < 12; i++)
    begin
      rnd = lfsr(rnd);
      cfg = i == 0 ? 6'b001011 : i == 1 ? 6'b110001 : rnd[5:0];
      alarm_code_in <= i == 1 ? 8'h2A : rnd[6] ? rnd[15:8] | 8'h01 : 8'h00;
      current_on_input <= rnd[16];
      seq_running <= i > 1 && rnd[17];
      startup_seq_exists <= i < 2 || rnd[18];
      delay <= rnd[22:19];
      bus(1, OFF_INT_MASK, {28'h0, {4{i[0]}}}, 4'hF);
      bus(1, OFF_CTRL, {25'h0, cfg, 1'b0}, 4'hF);
      bus(0, OFF_CTRL, 0, 4'hF);
      chk(q, {25'h0, cfg, 1'b0}, "control readback");
      n0 = n_done;
      s0 = starts;
      if (i[0])
      begin
        reset_cmd <= 1;
        @(posedge clk);
        reset_cmd <= 0;
        @(posedge clk);
      end
      else
        bus(1, OFF_CTRL, {25'h0, cfg, 1'b1}, 4'hF);
      repeat (2) @(posedge clk);
      // A second request while busy must leave the running sequence alone
      reset_cmd <= 1;
      @(posedge clk);
      reset_cmd <= 0;
      k = 0;
      do
      begin
        bus(0, OFF_STATUS, 0, 4'hF);
        k++;
      end
      while (q[ST_BUSY] !== 1'b0 && k < 100);
      pm = permit(cfg, alarm_code_in, current_on_input);
      st = alarm_code_in == 0 && !seq_running && startup_seq_exists;
      // An unconfigured brake pin keeps whatever the last sequence left on it
      brk = cfg[0] ? pm : brk;
      chk(n_done - n0, cfg[2:1] == VERB_BANNER ? 6 : 5, "service count");
      chk(cfg[2:1] == VERB_BANNER ? hist[23:0] : hist[19:0],
        cfg[2:1] == VERB_BANNER ? 24'h14823C : 20'h1483C, "service order");
      chk(q[15:0], {alarm_code_in, 1'b1, brk, pm, 5'h00}, "status");
      chk({motor_current_en, brake_release_output, outputs_follow, restart_hold},
        {pm, brk, 2'b10}, "drives");
      chk(starts - s0, st, "startup launch");
      chk(irq, i[0], "irq level");
      bus(0, OFF_INT_STAT, 0, 4'hF);
      chk(q, {alarm_code_in != 0, st, 2'b11}, "events");
      bus(0, OFF_INT_STAT, 0, 4'hF);
      chk({q[3:0], irq}, 0, "read clear");
    end
    bus(1, OFF_CTRL, 32'h1, 4'hF);
    repeat (6) @(posedge clk);
    rstn <= 0;
    repeat (2) @(posedge clk);
    chk({restart_hold, motor_current_en, svc_req, avs_waitrequest}, 7'h01, "values in reset");
    rstn <= 1;
    @(posedge clk);
    bus(0, OFF_STATUS, 0, 4'hF);
    chk(q, 0, "idle after reset");
    finish_test();
  end
endmodule
